// ==== src/rst_init_defines.vh ====
/*
  Constants for the reset initial-state logic: widths, reset classes,
  initial values of the program counter, stack pointer and ports,
  and the oscillator start-up wait.
  Assumes a single 25 MHz system clock and includers that use the names.
*/
// Operation
// - Watchdog time-out in sleep or idle keeps most state unchanged.
// - Sleep or idle time-out: clear PC and SP, set both flags.
// - Flags follow reset type; power-on clears both flags.
// - Supply-drop reset in fast or slow mode leaves both flags unchanged.
// - Running watchdog time-out sets timeout flag, keeps power-down flag.
// - Both flags are held as status bits software can read.
// - Power-on reset disables every interrupt source.
// - Reset clears watchdog and time bases; watchdog then counts again.
// - Power-on reset switches all timer modules off.
// - Power-on or running watchdog reset sets port data and direction high.
// - Power-on reset points the stack pointer at the stack top.
// - Registers take reset values per reset type; sleep time-out keeps most.
// - Power-on reset sets the program counter to zero.
// - Supply-drop reset sets its cause flag; only software or power-on reset clears it.
`ifndef RST_INIT_DEFINES_VH
`define RST_INIT_DEFINES_VH

// Widths
`define PC_W 14
`define SP_W 3
`define PORT_W 8
`define CLS_W 3
`define ST_W 2
`define OSC_CNT_W 11

// Reset classes
`define CLS_NONE 3'h0
`define CLS_POR 3'h1
`define CLS_LVR 3'h2
`define CLS_WDT_RUN 3'h3
`define CLS_WDT_SLEEP 3'h4

// Initial values
`define PC_RESET 14'h0000
`define SP_TOP 3'h0
`define PORT_RESET 8'hFF
`define FLAG_POR 1'b0
`define FLAG_SET 1'b1

// Oscillator start-up wait
`define CLK_PERIOD_NS 40
`define OSC_START_NS 40960
`define OSC_START_CYC ((`OSC_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== src/rst_event_sync.v ====
/*
  Three-stage synchroniser for event levels arriving from other clocks.
  Assumes inputs are levels that hold for several system clock cycles.
*/
`timescale 1ns/1ps
module rst_event_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Levels
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg out_reg;
      // A change counts only when stages two and three agree
      always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          out_reg <= 1'b0;
        end else begin
          s1_reg <= async_i[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
          end
        end
      end
      assign sync_o[g] = out_reg;
    end
  endgenerate
endmodule

// ==== src/reset_initial_state_logic.v ====
/*
  Reset initial-state sequencer: decides the reset class, keeps the
  timeout, power-down and supply-drop cause flags, and pulses the init
  strobes that set PC, SP, ports, interrupts, timers and counters.
  Assumes rst_i is the power-on reset, the watchdog and supply detector
  run on other clocks, and the core reports sleep or idle on mclk_i.
  A source that rises while a reset is being applied or the oscillator
  is starting is dropped; it must fall and rise again to be taken.
*/
`timescale 1ns/1ps
`include "rst_init_defines.vh"
module reset_initial_state_logic (
  // Clock and power-on reset
  input wire mclk_i,
  input wire rst_i,
  // Reset sources from other clock domains
  input wire watchdog_timer_timeout_i,
  input wire supply_drop_reset_i,
  // Core status and software controls
  input wire sleep_idle_i,
  input wire lv_flag_clear_i,
  // Status flags and reset class
  output wire timeout_flag_o,
  output wire power_down_flag_o,
  output wire low_voltage_reset_cause_flag_o,
  output wire [`CLS_W-1:0] reset_class_o,
  // Core control
  output wire cpu_hold_o,
  output wire pc_load_o,
  output wire [`PC_W-1:0] pc_value_o,
  output wire sp_load_o,
  output wire [`SP_W-1:0] sp_value_o,
  // Register file control
  output wire reg_init_o,
  output wire reg_keep_o,
  output wire port_load_o,
  output wire [`PORT_W-1:0] port_value_o,
  // Peripheral control
  output wire int_disable_o,
  output wire timer_off_o,
  output wire watchdog_timer_clear_o,
  output wire timebase_clear_o,
  output wire watchdog_timer_run_o
);
  wire [1:0] sync_w;
  wire wdt_lvl_w;
  wire lvr_lvl_w;
  reg wdt_prev_reg;
  reg lvr_prev_reg;
  wire wdt_rise_w;
  wire lvr_rise_w;

  reg [`ST_W-1:0] state_reg;
  reg [`ST_W-1:0] state_next;
  reg [`CLS_W-1:0] class_reg;
  reg [`CLS_W-1:0] class_next;
  reg [`OSC_CNT_W-1:0] osc_cnt_reg;
  reg [`OSC_CNT_W-1:0] osc_cnt_next;

  reg timeout_reg;
  reg timeout_next;
  reg pdown_reg;
  reg pdown_next;
  reg lv_cause_reg;
  reg lv_cause_next;

  reg hold_reg;
  reg hold_next;
  reg pc_load_reg;
  reg sp_load_reg;
  reg [`SP_W-1:0] sp_value_reg;
  reg [`SP_W-1:0] sp_value_next;
  reg reg_init_reg;
  reg reg_keep_reg;
  reg port_load_reg;
  reg int_dis_reg;
  reg timer_off_reg;
  reg wdt_clr_reg;
  reg tb_clr_reg;
  reg wdt_run_reg;
  reg wdt_run_next;
  reg [`PC_W-1:0] pc_value_reg;
  reg [`PORT_W-1:0] port_value_reg;

  reg apply_w;
  reg full_w;
  reg sleep_w;
  reg por_w;

  // Sequencer states
  localparam [`ST_W-1:0] ST_APPLY = 2'h0;
  localparam [`ST_W-1:0] ST_WAIT_OSC = 2'h1;
  localparam [`ST_W-1:0] ST_RUN = 2'h2;

  // Start-up wait in cycles, cut to the counter width on purpose
  localparam integer OSC_WAIT_INT = `OSC_START_CYC;
  localparam [`OSC_CNT_W-1:0] OSC_WAIT = OSC_WAIT_INT[`OSC_CNT_W-1:0];
  localparam [`OSC_CNT_W-1:0] CNT_ONE = 11'h001;
  localparam [`OSC_CNT_W-1:0] CNT_ZERO = 11'h000;

  // Bit 0 carries the watchdog, bit 1 the supply drop
  rst_event_sync #(
    .WIDTH(2)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({supply_drop_reset_i, watchdog_timer_timeout_i}),
    .sync_o(sync_w)
  );

  assign wdt_lvl_w = sync_w[0];
  assign lvr_lvl_w = sync_w[1];
  // Rising edges of the synchronised levels
  assign wdt_rise_w = wdt_lvl_w & ~wdt_prev_reg;
  // Supply-drop detector is off in sleep or idle
  assign lvr_rise_w = lvr_lvl_w & ~lvr_prev_reg & ~sleep_idle_i;

  // Decoding of the class being applied this cycle
  always @* begin
    apply_w = (state_reg == ST_APPLY);
    por_w = apply_w & (class_reg == `CLS_POR);
    sleep_w = apply_w & (class_reg == `CLS_WDT_SLEEP);
    full_w = apply_w & ((class_reg == `CLS_POR) |
                        (class_reg == `CLS_LVR) |
                        (class_reg == `CLS_WDT_RUN));
  end

  // Sequencer and flag next state
  always @* begin
    state_next = state_reg;
    class_next = class_reg;
    osc_cnt_next = osc_cnt_reg;
    timeout_next = timeout_reg;
    pdown_next = pdown_reg;
    lv_cause_next = lv_cause_reg;
    hold_next = hold_reg;
    sp_value_next = sp_value_reg;
    wdt_run_next = wdt_run_reg;
    if (lv_flag_clear_i) begin
      lv_cause_next = 1'b0;
    end
    case (state_reg)
      ST_APPLY: begin
        wdt_run_next = 1'b1;
        sp_value_next = `SP_TOP;
        // Start-up wait only after a sleep time-out
        if (class_reg == `CLS_WDT_SLEEP) begin
          state_next = ST_WAIT_OSC;
          osc_cnt_next = OSC_WAIT;
        end else begin
          state_next = ST_RUN;
          hold_next = 1'b0;
        end
      end
      ST_WAIT_OSC: begin
        // Source edges seen here are lost
        if (osc_cnt_reg == CNT_ONE) begin
          state_next = ST_RUN;
          hold_next = 1'b0;
          osc_cnt_next = CNT_ZERO;
        end else begin
          osc_cnt_next = osc_cnt_reg - CNT_ONE;
        end
      end
      ST_RUN: begin
        // Supply drop wins over a watchdog edge in the same cycle
        if (lvr_rise_w) begin
          state_next = ST_APPLY;
          class_next = `CLS_LVR;
          hold_next = 1'b1;
          wdt_run_next = 1'b0;
          lv_cause_next = 1'b1;
        end else if (wdt_rise_w) begin
          state_next = ST_APPLY;
          hold_next = 1'b1;
          wdt_run_next = 1'b0;
          timeout_next = `FLAG_SET;
          if (sleep_idle_i) begin
            class_next = `CLS_WDT_SLEEP;
            pdown_next = `FLAG_SET;
          end else begin
            class_next = `CLS_WDT_RUN;
          end
        end
      end
      default: begin
        state_next = ST_RUN;
        hold_next = 1'b0;
      end
    endcase
  end

  // State and flags
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_APPLY;
      class_reg <= `CLS_POR;
      osc_cnt_reg <= 11'h000;
      timeout_reg <= `FLAG_POR;
      pdown_reg <= `FLAG_POR;
      lv_cause_reg <= 1'b0;
      hold_reg <= 1'b1;
      sp_value_reg <= `SP_TOP;
      wdt_run_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      class_reg <= class_next;
      osc_cnt_reg <= osc_cnt_next;
      timeout_reg <= timeout_next;
      pdown_reg <= pdown_next;
      lv_cause_reg <= lv_cause_next;
      hold_reg <= hold_next;
      sp_value_reg <= sp_value_next;
      wdt_run_reg <= wdt_run_next;
    end
  end

  // Previous levels tracked in every state, so a source that rose
  // during apply or start-up wait is dropped, not taken late
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_prev_reg <= 1'b0;
      lvr_prev_reg <= 1'b0;
    end else begin
      wdt_prev_reg <= wdt_lvl_w;
      lvr_prev_reg <= lvr_lvl_w;
    end
  end

  // One-cycle init strobes, issued the edge after a reset is taken
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_load_reg <= 1'b0;
      sp_load_reg <= 1'b0;
      reg_init_reg <= 1'b0;
      reg_keep_reg <= 1'b0;
      port_load_reg <= 1'b0;
      int_dis_reg <= 1'b0;
      timer_off_reg <= 1'b0;
      wdt_clr_reg <= 1'b0;
      tb_clr_reg <= 1'b0;
    end else begin
      pc_load_reg <= apply_w;
      sp_load_reg <= apply_w;
      reg_init_reg <= full_w;
      reg_keep_reg <= sleep_w;
      port_load_reg <= full_w;
      int_dis_reg <= full_w | por_w;
      timer_off_reg <= full_w | por_w;
      wdt_clr_reg <= apply_w;
      tb_clr_reg <= apply_w;
    end
  end

  // Load values kept in flops so every output is registered; they
  // never change, so the flops cost area only
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_value_reg <= `PC_RESET;
      port_value_reg <= `PORT_RESET;
    end else begin
      pc_value_reg <= `PC_RESET;
      port_value_reg <= `PORT_RESET;
    end
  end

  assign timeout_flag_o = timeout_reg;
  assign power_down_flag_o = pdown_reg;
  assign low_voltage_reset_cause_flag_o = lv_cause_reg;
  assign reset_class_o = class_reg;
  assign cpu_hold_o = hold_reg;
  assign pc_load_o = pc_load_reg;
  assign pc_value_o = pc_value_reg;
  assign sp_load_o = sp_load_reg;
  assign sp_value_o = sp_value_reg;
  assign reg_init_o = reg_init_reg;
  assign reg_keep_o = reg_keep_reg;
  assign port_load_o = port_load_reg;
  assign port_value_o = port_value_reg;
  assign int_disable_o = int_dis_reg;
  assign timer_off_o = timer_off_reg;
  assign watchdog_timer_clear_o = wdt_clr_reg;
  assign timebase_clear_o = tb_clr_reg;
  assign watchdog_timer_run_o = wdt_run_reg;
endmodule

// ==== bench/reset_initial_state_chk.sv ====
/*
  Port checker for the reset initial-state sequencer.
  Bound to the design top from the bench; sees only its ports.
*/
`timescale 1ns/1ps
`include "rst_init_defines.vh"
module reset_initial_state_chk (
  // Clock, reset and supply-drop cause flag clear
  input wire mclk_i,
  input wire rst_i,
  input wire lv_flag_clear_i,
  // Observed outputs
  input wire timeout_flag_o,
  input wire power_down_flag_o,
  input wire low_voltage_reset_cause_flag_o,
  input wire [`CLS_W-1:0] reset_class_o,
  input wire cpu_hold_o,
  input wire pc_load_o,
  input wire [`PC_W-1:0] pc_value_o,
  input wire sp_load_o,
  input wire [`SP_W-1:0] sp_value_o,
  input wire reg_init_o,
  input wire reg_keep_o,
  input wire port_load_o,
  input wire [`PORT_W-1:0] port_value_o,
  input wire int_disable_o,
  input wire timer_off_o,
  input wire watchdog_timer_clear_o,
  input wire timebase_clear_o,
  input wire watchdog_timer_run_o
);
  localparam int OSC_HOLD = `OSC_START_CYC + 1;
  logic [11:0] hold_cnt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Sampled hold cycles; cleared when hold drops
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) hold_cnt <= 12'h000;
    else hold_cnt <= cpu_hold_o ? hold_cnt + 12'h001 : 12'h000;
  end
  property p_sleep;
    reg_keep_o |-> timeout_flag_o && power_down_flag_o && !reg_init_o
      && !port_load_o && reset_class_o == `CLS_WDT_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep reset wrong");
  property p_pc;
    pc_load_o |-> pc_value_o == `PC_RESET && sp_load_o
      && sp_value_o == `SP_TOP;
  endproperty
  a_pc: assert property (p_pc) else $error("pc or sp load wrong");
  property p_port;
    port_load_o |-> port_value_o == `PORT_RESET && reg_init_o;
  endproperty
  a_port: assert property (p_port) else $error("port value wrong");
  property p_run;
    reset_class_o == `CLS_WDT_RUN && pc_load_o |->
      power_down_flag_o == $past(power_down_flag_o, 2) && timeout_flag_o;
  endproperty
  a_run: assert property (p_run) else $error("running wdt flags");
  property p_lvr;
    reset_class_o == `CLS_LVR && pc_load_o |->
      timeout_flag_o == $past(timeout_flag_o, 2)
      && power_down_flag_o == $past(power_down_flag_o, 2)
      && low_voltage_reset_cause_flag_o;
  endproperty
  a_lvr: assert property (p_lvr) else $error("supply drop flags");
  property p_por;
    reset_class_o == `CLS_POR && pc_load_o |-> !timeout_flag_o
      && !power_down_flag_o && int_disable_o && timer_off_o;
  endproperty
  a_por: assert property (p_por) else $error("power-on state wrong");
  property p_wdt;
    pc_load_o |-> watchdog_timer_clear_o && timebase_clear_o
      && watchdog_timer_run_o;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog not cleared");
  property p_ans;
    $rose(cpu_hold_o) |-> !watchdog_timer_run_o ##1 pc_load_o;
  endproperty
  a_ans: assert property (p_ans) else $error("no strobe after hold");
  property p_keep;
    reg_keep_o |-> cpu_hold_o [*8];
  endproperty
  a_keep: assert property (p_keep) else $error("sleep hold too short");
  property p_osc;
    $fell(cpu_hold_o) && reset_class_o == `CLS_WDT_SLEEP
      |-> hold_cnt == OSC_HOLD;
  endproperty
  a_osc: assert property (p_osc) else $error("start-up wait wrong");
  property p_lvf;
    $fell(low_voltage_reset_cause_flag_o) |-> $past(lv_flag_clear_i);
  endproperty
  a_lvf: assert property (p_lvf) else $error("cause flag lost");
endmodule

// ==== bench/test_reset_initial_state_logic.sv ====
/*
  Bench for the reset sequencer: raises reset sources, checks strobes.
  Assumes the design and checker files are compiled before it.
*/
`timescale 1ns/1ps
`include "rst_init_defines.vh"
module test_reset_initial_state_logic;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic watchdog_timer_timeout_i = 1'b0;
  logic supply_drop_reset_i = 1'b0;
  logic sleep_idle_i = 1'b0;
  logic lv_flag_clear_i = 1'b0;
  wire timeout_flag_o, power_down_flag_o, low_voltage_reset_cause_flag_o;
  wire cpu_hold_o, pc_load_o, sp_load_o, reg_init_o, reg_keep_o;
  wire port_load_o, int_disable_o, timer_off_o, watchdog_timer_clear_o;
  wire timebase_clear_o, watchdog_timer_run_o;
  wire [`CLS_W-1:0] reset_class_o;
  wire [`PC_W-1:0] pc_value_o;
  wire [`SP_W-1:0] sp_value_o;
  wire [`PORT_W-1:0] port_value_o;
  logic [38:0] q[$];
  logic to_m = 1'b0;
  logic pd_m = 1'b0;
  logic lv_m = 1'b0;
  logic [31:0] rnd = 32'h7c4a_2cbb;
  int error_cnt = 0;
  int n_tests = 0;
  always #20 mclk_i = ~mclk_i;
  reset_initial_state_logic dut_u (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Sleep time-out keeps registers; all others initialise
  function automatic logic [38:0] mk(input logic [2:0] c);
    logic i;
    i = (c != 3'h4);
    return {to_m, pd_m, lv_m, c, i, !i, i, i, i, 3'h7, 14'h0000, 3'h0,
      8'hff};
  endfunction
  task automatic chk(input logic [38:0] e, input logic [38:0] o);
    n_tests++;
    if (o !== e) begin
      error_cnt++;
      $display("[ERR] %0t exp %h got %h", $time, e, o);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A strobe with nothing queued compares against zero and fails
  always @(negedge mclk_i) begin
    if (pc_load_o === 1'b1) begin
      chk(q.size() > 0 ? q.pop_front() : 39'h0, {timeout_flag_o,
        power_down_flag_o, low_voltage_reset_cause_flag_o, reset_class_o,
        reg_init_o, reg_keep_o, port_load_o, int_disable_o, timer_off_o,
        watchdog_timer_clear_o, timebase_clear_o, sp_load_o, pc_value_o,
        sp_value_o, port_value_o});
    end
  end
  task automatic clr;
    @(negedge mclk_i);
    lv_flag_clear_i = 1'b1;
    @(negedge mclk_i);
    lv_flag_clear_i = 1'b0;
    lv_m = 1'b0;
  endtask
  // Supply drop in sleep is ignored, so nothing is queued
  task automatic ev(input logic s, input logic l);
    int w;
    w = 5 + rnd[2:0];
    rnd = lfsr(rnd);
    @(negedge mclk_i);
    sleep_idle_i = l;
    if (!(s && l)) begin
      if (s) lv_m = 1'b1;
      else to_m = 1'b1;
      pd_m = pd_m | (l && !s);
      q.push_back(mk(s ? 3'h2 : l ? 3'h4 : 3'h3));
    end
    if (s) supply_drop_reset_i = 1'b1;
    else watchdog_timer_timeout_i = 1'b1;
    repeat (w) @(negedge mclk_i);
    supply_drop_reset_i = 1'b0;
    watchdog_timer_timeout_i = 1'b0;
    repeat (l ? 1100 : 8) @(negedge mclk_i);
    sleep_idle_i = 1'b0;
  endtask
  initial begin
    q.push_back(mk(3'h1));
    repeat (4) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    ev(1'b0, 1'b0);
    ev(1'b1, 1'b0);
    ev(1'b1, 1'b1);
    clr();
    ev(1'b0, 1'b1);
    ev(1'b0, 1'b0);
    ev(1'b1, 1'b0);
    for (int k = 0; k < 6; k++) begin
      if (rnd[3]) clr();
      ev(rnd[4], rnd[5]);
    end
    // Power-on reset mid-run must clear the flags set above
    @(negedge mclk_i);
    rst_i = 1'b1;
    to_m = 1'b0;
    pd_m = 1'b0;
    lv_m = 1'b0;
    q.push_back(mk(3'h1));
    repeat (4) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    chk(39'(q.size()), 39'h0);
    end_of_test();
  end
  initial begin
    #2_000_000;
    error_cnt++;
    end_of_test();
  end
endmodule
bind reset_initial_state_logic reset_initial_state_chk chk_u (.*);
